// file: core/drs_pkg.sv
// Package: constants and types for the drive reference and relay select block
package drs_pkg;
   // Clock rate and timing
   localparam int CLK_HZ = 20000000;
   localparam int AI_FLOOR_MS = 25;
   localparam int AI_FLOOR_CYC = (AI_FLOOR_MS * (CLK_HZ / 1000)) / 16;
   localparam int DIV_FILT_MS = 1;
   localparam int DIV_FILT_CYC = DIV_FILT_MS * (CLK_HZ / 1000);
   localparam int RAMP_DIV_CYC = 2000;
   // Widths
   localparam int AW = 12;
   localparam int FW = 16;
   localparam logic [15:0] CONST_MAX_HZ_X10 = 16'h09c4;
   // Reset values
   localparam logic [15:0] REF_RST = 16'h0000;
   localparam logic [AW-1:0] AI_RST = 12'h000;
   localparam logic [AW-1:0] AI_FULL = 12'hfff;
   // Reference source codes
   localparam logic [3:0] SRC_PANEL = 4'h0;
   localparam logic [3:0] SRC_AI1 = 4'h1;
   localparam logic [3:0] SRC_AI2 = 4'h2;
   localparam logic [3:0] SRC_UPDN_RST = 4'h5;
   localparam logic [3:0] SRC_UPDN_KEEP = 4'h6;
   localparam logic [3:0] SRC_UPDN_45 = 4'h7;
   localparam logic [3:0] SRC_COMM = 4'h8;
   localparam logic [3:0] SRC_COMM_SUM = 4'h9;
   localparam logic [3:0] SRC_COMM_MUL = 4'ha;
   // Constant speed selector codes
   localparam logic [3:0] CS_OFF = 4'h0;
   localparam logic [3:0] CS_PAIR12 = 4'h6;
   localparam logic [3:0] CS_PAIR34 = 4'h7;
   localparam logic [3:0] CS_PAIR45 = 4'h8;
   localparam logic [3:0] CS_TRI123 = 4'h9;
   localparam logic [3:0] CS_TRI345 = 4'ha;
   // Relay source codes
   localparam logic [4:0] RLY_OFF = 5'h00;
   localparam logic [4:0] RLY_READY = 5'h01;
   localparam logic [4:0] RLY_RUN = 5'h02;
   localparam logic [4:0] RLY_FAULT_N = 5'h03;
   localparam logic [4:0] RLY_FAULT = 5'h04;
   localparam logic [4:0] RLY_ALARM = 5'h05;
   localparam logic [4:0] RLY_REV = 5'h06;
   localparam logic [4:0] RLY_S1_OVER = 5'h07;
   localparam logic [4:0] RLY_S1_UNDER = 5'h08;
   localparam logic [4:0] RLY_S2_OVER = 5'h09;
   localparam logic [4:0] RLY_S2_UNDER = 5'h0a;
   localparam logic [4:0] RLY_AT_REF = 5'h0b;
   localparam logic [4:0] RLY_EXT = 5'h0e;
   localparam logic [4:0] RLY_LOC2 = 5'h0f;
   localparam logic [4:0] RLY_CONST = 5'h10;
   // Location select: 1..5 digital input, 6 loc1, 7 loc2, 8 serial
   localparam logic [3:0] LOC_FIX1 = 4'h6;
   localparam logic [3:0] LOC_FIX2 = 4'h7;
   localparam logic [3:0] LOC_COMM = 4'h8;
   typedef enum logic [1:0] {DRS_RAMP_IDLE, DRS_RAMP_RUN} drs_ramp_t;
endpackage

// file: core/drs_ai_filter.sv
// Analogue input scaling window, fixed floor filter and programmable filter
`timescale 1ns/1ps
module drs_ai_filter
   import drs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [AW-1:0] ai_raw,
   input wire logic [7:0] ai_min_pct,
   input wire logic [7:0] ai_max_pct,
   input wire logic [3:0] ai_tc_shift,
   output logic [AW-1:0] ai_scaled
);
   logic [FW-1:0] floor_r;
   logic [FW-1:0] prog_r;
   logic [15:0] cnt_r;
   logic [15:0] slow_r;
   logic tick;
   logic [7:0] lo_pct;
   logic [AW-1:0] lo;
   logic [AW-1:0] hi;
   logic [AW-1:0] prog_v;
   logic [AW+8:0] num;
   logic signed [FW:0] floor_gap;
   logic signed [FW:0] prog_gap;

   // Signed gaps so a falling input pulls both stages down too
   assign floor_gap = $signed({1'b0, ai_raw, 4'h0})
                      - $signed({1'b0, floor_r});
   assign prog_gap = $signed({1'b0, floor_r}) - $signed({1'b0, prog_r});

   assign tick = (cnt_r == 16'(AI_FLOOR_CYC - 1));

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cnt_r <= 16'h0000;
      end else if (tick) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // Fixed 25 ms first order stage; no setting bypasses it
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         floor_r <= 16'h0000;
      end else if (tick) begin
         floor_r <= floor_r + FW'(floor_gap >>> 4);
      end
   end

   // Programmable stage: time constant in powers of two of the floor step
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         slow_r <= 16'h0000;
         prog_r <= 16'h0000;
      end else if (tick) begin
         if (ai_tc_shift == 4'h0 || slow_r == 16'h0000) begin
            slow_r <= (16'h0001 << ai_tc_shift) - 16'h0001;
            if (ai_tc_shift == 4'h0) begin
               prog_r <= floor_r;
            end else begin
               // 1/16 of the gap per step gives ~63 % after 16 steps
               prog_r <= prog_r + FW'(prog_gap >>> 4);
            end
         end else begin
            slow_r <= slow_r - 16'h0001;
         end
      end
   end

   // Minimum never above maximum: low end is clamped to the high end
   assign lo_pct = (ai_min_pct > ai_max_pct) ? ai_max_pct : ai_min_pct;
   assign lo = AW'((32'(lo_pct) * 32'(AI_FULL)) / 32'd100);
   assign hi = AW'((32'(ai_max_pct) * 32'(AI_FULL)) / 32'd100);
   assign prog_v = prog_r[FW-1:4];
   assign num = (AW+9)'(32'(prog_v - lo) * 32'(AI_FULL)
                / 32'((hi == lo) ? 12'h001 : hi - lo));

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ai_scaled <= AI_RST;
      end else if (prog_v <= lo) begin
         ai_scaled <= AI_RST;
      end else if (prog_v >= hi) begin
         ai_scaled <= AI_FULL;
      end else begin
         ai_scaled <= num[AW-1:0];
      end
   end
endmodule

// file: core/drs_ref_path.sv
// One external reference path: source mux, scaling and motor potentiometer
`timescale 1ns/1ps
module drs_ref_path
   import drs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [3:0] src_sel,
   input wire logic [15:0] low_limit,
   input wire logic [15:0] high_limit,
   input wire logic [AW-1:0] ai1,
   input wire logic [AW-1:0] ai2,
   input wire logic [15:0] panel_ref,
   input wire logic [15:0] comm_ref,
   input wire logic [4:0] din,
   input wire logic run_cmd,
   input wire logic ramp_tick,
   output logic [15:0] ref_out
);
   logic [15:0] updn_r;
   logic [15:0] ai_ref;
   logic [AW-1:0] ai_pick;
   logic [15:0] ref_nxt;
   logic up;
   logic dn;

   assign ai_pick = (src_sel == SRC_AI2) ? ai2 : ai1;
   assign ai_ref = low_limit + 16'((32'(high_limit - low_limit)
                   * 32'(ai_pick)) / 32'(AI_FULL));
   assign up = (src_sel == SRC_UPDN_45) ? din[3] : din[2];
   assign dn = (src_sel == SRC_UPDN_45) ? din[4] : din[3];

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         updn_r <= REF_RST;
      end else if (src_sel == SRC_UPDN_RST && !run_cmd) begin
         updn_r <= REF_RST;
      end else if (ramp_tick && run_cmd && up && !dn
                   && updn_r != high_limit) begin
         updn_r <= updn_r + 16'h0001;
      end else if (ramp_tick && run_cmd && dn && !up
                   && updn_r != 16'h0000) begin
         updn_r <= updn_r - 16'h0001;
      end
   end

   always_comb begin
      case (src_sel)
         SRC_PANEL: ref_nxt = panel_ref;
         SRC_AI1, SRC_AI2: ref_nxt = ai_ref;
         SRC_UPDN_RST, SRC_UPDN_KEEP, SRC_UPDN_45: ref_nxt = updn_r;
         SRC_COMM: ref_nxt = comm_ref;
         SRC_COMM_SUM: ref_nxt = comm_ref + ai_ref;
         SRC_COMM_MUL: ref_nxt = 16'((32'(comm_ref) * 32'(ai_pick))
                                 / 32'(AI_FULL));
         default: ref_nxt = ai_ref;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ref_out <= REF_RST;
      end else begin
         ref_out <= ref_nxt;
      end
   end
endmodule

// file: core/drs_top.sv
// Top: reference selection, constant speeds and relay output source mux
`timescale 1ns/1ps
module drs_top
   import drs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic digital_in_1,
   input wire logic digital_in_2,
   input wire logic digital_in_3,
   input wire logic digital_in_4,
   input wire logic digital_in_5,
   input wire logic [AW-1:0] analog_in_1,
   input wire logic [AW-1:0] analog_in_2,
   input wire logic [7:0] ai1_min_pct,
   input wire logic [7:0] ai1_max_pct,
   input wire logic [3:0] analog_1_time_constant,
   input wire logic [7:0] ai2_min_pct,
   input wire logic [7:0] ai2_max_pct,
   input wire logic [3:0] analog_2_time_constant,
   input wire logic [3:0] ref1_source,
   input wire logic [3:0] ref2_source,
   input wire logic [15:0] ref1_low_limit,
   input wire logic [15:0] ref1_high_limit,
   input wire logic [7:0] ref2_low_limit,
   input wire logic [7:0] ref2_high_limit,
   input wire logic [15:0] max_frequency,
   input wire logic process_macro,
   input wire logic [15:0] panel_ref,
   input wire logic [15:0] comm_ref,
   input wire logic [3:0] location_select,
   input wire logic comm_location_2,
   input wire logic local_control,
   input wire logic pump_fan_control,
   input wire logic process_ref_followed,
   input wire logic [3:0] const_speed_select,
   input wire logic [15:0] const_speed_1,
   input wire logic [15:0] const_speed_2,
   input wire logic [15:0] const_speed_3,
   input wire logic [15:0] const_speed_4,
   input wire logic [15:0] const_speed_5,
   input wire logic [15:0] const_speed_6,
   input wire logic [15:0] const_speed_7,
   input wire logic run_cmd,
   input wire logic [4:0] relay_source,
   input wire logic drive_ready,
   input wire logic run_enable,
   input wire logic running,
   input wire logic fault_active,
   input wire logic alarm_active,
   input wire logic reverse_rotation,
   input wire logic supv1_over,
   input wire logic supv1_under,
   input wire logic supv2_over,
   input wire logic supv2_under,
   input wire logic frequency_reached,
   output logic [15:0] ext_ref1,
   output logic [15:0] ext_ref2,
   output logic ref2_is_process,
   output logic external_location_2,
   output logic [2:0] const_speed_index,
   output logic [15:0] const_speed_ref,
   output logic [15:0] fallback_speed,
   output logic relay_out_1
);
   // ------------------------------------------------------------
   // Analogue inputs
   // ------------------------------------------------------------
   logic [AW-1:0] ai1_f;
   logic [AW-1:0] ai2_f;

   drs_ai_filter u_ai1 (
      .clk_sys(clk_sys),
      .reset(reset),
      .ai_raw(analog_in_1),
      .ai_min_pct(ai1_min_pct),
      .ai_max_pct(ai1_max_pct),
      .ai_tc_shift(analog_1_time_constant),
      .ai_scaled(ai1_f)
   );

   drs_ai_filter u_ai2 (
      .clk_sys(clk_sys),
      .reset(reset),
      .ai_raw(analog_in_2),
      .ai_min_pct(ai2_min_pct),
      .ai_max_pct(ai2_max_pct),
      .ai_tc_shift(analog_2_time_constant),
      .ai_scaled(ai2_f)
   );

   // ------------------------------------------------------------
   // Up/down ramp rate divider
   // ------------------------------------------------------------
   logic [15:0] ramp_cnt_r;
   logic ramp_tick;
   logic [4:0] din;

   assign din = {digital_in_5, digital_in_4, digital_in_3,
                 digital_in_2, digital_in_1};
   assign ramp_tick = (ramp_cnt_r == 16'(RAMP_DIV_CYC - 1));

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ramp_cnt_r <= 16'h0000;
      end else if (ramp_tick) begin
         ramp_cnt_r <= 16'h0000;
      end else begin
         ramp_cnt_r <= ramp_cnt_r + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // External references
   // ------------------------------------------------------------
   logic [15:0] ref2_lo;
   logic [15:0] ref2_hi;
   logic [15:0] ref1_w;
   logic [15:0] ref2_w;

   // Percent of maximum frequency; same scale serves process reference
   assign ref2_lo = 16'((32'(ref2_low_limit) * 32'(max_frequency))
                    / 32'd100);
   assign ref2_hi = 16'((32'(ref2_high_limit) * 32'(max_frequency))
                    / 32'd100);

   drs_ref_path u_ref1 (
      .clk_sys(clk_sys),
      .reset(reset),
      .src_sel(ref1_source),
      .low_limit(ref1_low_limit),
      .high_limit(ref1_high_limit),
      .ai1(ai1_f),
      .ai2(ai2_f),
      .panel_ref(panel_ref),
      .comm_ref(comm_ref),
      .din(din),
      .run_cmd(run_cmd),
      .ramp_tick(ramp_tick),
      .ref_out(ref1_w)
   );

   // Same path module, so the same source codes apply
   drs_ref_path u_ref2 (
      .clk_sys(clk_sys),
      .reset(reset),
      .src_sel(ref2_source),
      .low_limit(ref2_lo),
      .high_limit(ref2_hi),
      .ai1(ai1_f),
      .ai2(ai2_f),
      .panel_ref(panel_ref),
      .comm_ref(comm_ref),
      .din(din),
      .run_cmd(run_cmd),
      .ramp_tick(ramp_tick),
      .ref_out(ref2_w)
   );

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ext_ref1 <= REF_RST;
         ext_ref2 <= REF_RST;
         ref2_is_process <= 1'b0;
      end else begin
         ext_ref1 <= ref1_w;
         ext_ref2 <= ref2_w;
         ref2_is_process <= process_macro | pump_fan_control;
      end
   end

   // ------------------------------------------------------------
   // Control location
   // ------------------------------------------------------------
   logic loc2_nxt;
   logic [2:0] loc_idx;

   assign loc_idx = 3'(location_select - 4'h1);

   always_comb begin
      if (location_select >= 4'h1 && location_select <= 4'h5) begin
         loc2_nxt = din[loc_idx];
      end else if (location_select == LOC_FIX2) begin
         loc2_nxt = 1'b1;
      end else if (location_select == LOC_COMM) begin
         loc2_nxt = comm_location_2;
      end else begin
         loc2_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         external_location_2 <= 1'b0;
      end else begin
         external_location_2 <= loc2_nxt;
      end
   end

   // ------------------------------------------------------------
   // Constant speeds
   // ------------------------------------------------------------
   logic [15:0] cs_raw [7];
   logic [15:0] cs_lim [7];
   logic [2:0] cs_idx_nxt;
   logic [2:0] single_idx;

   assign cs_raw[0] = const_speed_1;
   assign cs_raw[1] = const_speed_2;
   assign cs_raw[2] = const_speed_3;
   assign cs_raw[3] = const_speed_4;
   assign cs_raw[4] = const_speed_5;
   assign cs_raw[5] = const_speed_6;
   assign cs_raw[6] = const_speed_7;

   // Signed values at or below zero read as zero, top is 250.0 Hz
   for (genvar i = 0; i < 7; i++) begin : g_cs
      assign cs_lim[i] = cs_raw[i][15] ? 16'h0000 :
         (cs_raw[i] > CONST_MAX_HZ_X10 ? CONST_MAX_HZ_X10 : cs_raw[i]);
   end

   assign single_idx = 3'(const_speed_select - 4'h1);

   always_comb begin
      case (const_speed_select)
         CS_OFF: cs_idx_nxt = 3'h0;
         4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
            cs_idx_nxt = {2'b00, din[single_idx]};
         CS_PAIR12: cs_idx_nxt = {1'b0, din[1], din[0]};
         CS_PAIR34: cs_idx_nxt = {1'b0, din[3], din[2]};
         CS_PAIR45: cs_idx_nxt = {1'b0, din[4], din[3]};
         CS_TRI123: cs_idx_nxt = {din[2], din[1], din[0]};
         CS_TRI345: cs_idx_nxt = {din[4], din[3], din[2]};
         default: cs_idx_nxt = 3'h0;
      endcase
      if (process_ref_followed || local_control || pump_fan_control) begin
         cs_idx_nxt = 3'h0;
      end
   end

   // Registered one cycle after the inputs; contact bounces are not filtered out
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         const_speed_index <= 3'h0;
         const_speed_ref <= REF_RST;
         fallback_speed <= REF_RST;
      end else begin
         const_speed_index <= cs_idx_nxt;
         const_speed_ref <= (cs_idx_nxt == 3'h0) ? REF_RST :
                            cs_lim[cs_idx_nxt - 3'h1];
         fallback_speed <= cs_lim[6];
      end
   end

   // ------------------------------------------------------------
   // Relay output 1
   // ------------------------------------------------------------
   logic relay_nxt;

   always_comb begin
      case (relay_source)
         RLY_OFF: relay_nxt = 1'b0;
         RLY_READY:
            relay_nxt = drive_ready & run_enable & ~fault_active;
         RLY_RUN: relay_nxt = running;
         RLY_FAULT_N: relay_nxt = ~fault_active;
         RLY_FAULT: relay_nxt = fault_active;
         RLY_ALARM: relay_nxt = alarm_active;
         RLY_REV: relay_nxt = reverse_rotation;
         RLY_S1_OVER: relay_nxt = supv1_over;
         RLY_S1_UNDER: relay_nxt = supv1_under;
         RLY_S2_OVER: relay_nxt = supv2_over;
         RLY_S2_UNDER: relay_nxt = supv2_under;
         RLY_AT_REF: relay_nxt = frequency_reached;
         RLY_EXT: relay_nxt = ~local_control;
         RLY_LOC2: relay_nxt = loc2_nxt;
         RLY_CONST: relay_nxt = (cs_idx_nxt != 3'h0);
         default: relay_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         relay_out_1 <= 1'b0;
      end else begin
         relay_out_1 <= relay_nxt;
      end
   end
endmodule

// file: verif/drs_far_end.sv
// Far side model: input contacts, analogue input 1 and fieldbus master
`timescale 1ns/1ps
module drs_far_end
   import drs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [4:0] din_set,
   input wire logic [AW-1:0] ai_set,
   input wire logic [15:0] comm_set,
   output logic digital_in_1,
   output logic digital_in_2,
   output logic digital_in_3,
   output logic digital_in_4,
   output logic digital_in_5,
   output logic [AW-1:0] analog_in_1,
   output logic [15:0] comm_ref
);
   // Contacts and master values move only just after an edge
   always_ff @(posedge clk_sys) begin
      {digital_in_5, digital_in_4, digital_in_3, digital_in_2,
         digital_in_1} <= din_set;
      analog_in_1 <= ai_set;
      comm_ref <= comm_set;
   end
endmodule

// file: verif/drs_top_monitor.sv
// Checker of relay source, constant speed decode and location select
`timescale 1ns/1ps
module drs_top_monitor
   import drs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic digital_in_1,
   input wire logic digital_in_2,
   input wire logic digital_in_3,
   input wire logic digital_in_4,
   input wire logic digital_in_5,
   input wire logic [3:0] location_select,
   input wire logic local_control,
   input wire logic pump_fan_control,
   input wire logic process_ref_followed,
   input wire logic [3:0] const_speed_select,
   input wire logic [4:0] relay_source,
   input wire logic drive_ready,
   input wire logic run_enable,
   input wire logic fault_active,
   input wire logic reverse_rotation,
   input wire logic supv1_under,
   input wire logic frequency_reached,
   input wire logic [2:0] const_speed_index,
   input wire logic external_location_2,
   input wire logic relay_out_1
);
   logic [1:0] up_r;
   logic live;
   logic inh;
   // Skip the first edges after reset, where outputs are held at zero
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         up_r <= 2'h0;
      end else if (up_r != 2'h3) begin
         up_r <= up_r + 2'h1;
      end
   end
   assign live = (up_r == 2'h3);
   assign inh = local_control | pump_fan_control | process_ref_followed;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_relay_off: assert property (live && relay_source == RLY_OFF
      |=> !relay_out_1) else $error("relay on with source off");
   a_relay_ready: assert property (live && relay_source == RLY_READY
      |=> relay_out_1 == $past(drive_ready & run_enable & !fault_active))
      else $error("relay ready wrong");
   a_relay_fault: assert property (live && relay_source == RLY_FAULT
      |=> relay_out_1 == $past(fault_active)) else $error("fault relay");
   a_relay_reverse: assert property (live && relay_source == RLY_REV
      ##1 relay_source == RLY_REV |-> relay_out_1 == $past(reverse_rotation))
      else $error("reverse relay wrong");
   a_supv_under: assert property (live && relay_source == RLY_S1_UNDER
      |=> relay_out_1 == $past(supv1_under)) else $error("supv relay");
   a_at_ref: assert property (live && relay_source == RLY_AT_REF
      |=> relay_out_1 == $past(frequency_reached)) else $error("at ref");
   a_pair_decode: assert property (live && !inh
      && const_speed_select == CS_PAIR12 |=> const_speed_index ==
      {1'b0, $past(digital_in_2), $past(digital_in_1)})
      else $error("pair decode wrong");
   a_tri_decode: assert property (live && !inh
      && const_speed_select == CS_TRI345 |=> const_speed_index ==
      {$past(digital_in_5), $past(digital_in_4), $past(digital_in_3)})
      else $error("triple decode wrong");
   a_const_refused: assert property ((live && inh) [*2]
      |-> const_speed_index == 3'h0) else $error("speed not refused");
   a_loc_input: assert property (live && location_select == 4'h1
      |=> external_location_2 == $past(digital_in_1))
      else $error("location from input wrong");
   c_fault: cover property (relay_source == RLY_FAULT && fault_active);
   c_tri: cover property (const_speed_select == CS_TRI345
      && const_speed_index == 3'h7);
   c_loc2: cover property (external_location_2);
endmodule
bind drs_top drs_top_monitor i_drs_top_monitor (.*);

// file: verif/drs_top_tb_top.sv
// Testbench for the drive reference and relay select block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
   err_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module drs_top_tb_top;
   import drs_pkg::*;
   logic clk_sys, reset, digital_in_1, digital_in_2, digital_in_3;
   logic digital_in_4, digital_in_5, process_macro, comm_location_2;
   logic local_control, pump_fan_control, process_ref_followed, run_cmd;
   logic drive_ready, run_enable, running, fault_active, alarm_active;
   logic reverse_rotation, supv1_over, supv1_under, supv2_over;
   logic supv2_under, frequency_reached, ref2_is_process;
   logic external_location_2, relay_out_1;
   logic [AW-1:0] analog_in_1, analog_in_2, ai_set;
   logic [7:0] ai1_min_pct, ai1_max_pct, ai2_min_pct, ai2_max_pct;
   logic [7:0] ref2_low_limit, ref2_high_limit;
   logic [3:0] analog_1_time_constant, analog_2_time_constant;
   logic [3:0] ref1_source, ref2_source, location_select;
   logic [3:0] const_speed_select;
   logic [15:0] ref1_low_limit, ref1_high_limit, max_frequency, panel_ref;
   logic [15:0] comm_ref, comm_set, ext_ref1, ext_ref2, const_speed_ref;
   logic [15:0] fallback_speed, const_speed_1, const_speed_2;
   logic [15:0] const_speed_3, const_speed_4, const_speed_5;
   logic [15:0] const_speed_6, const_speed_7;
   logic [4:0] relay_source, din_set;
   logic [2:0] const_speed_index;
   int err_count, comparisons, cycles, sh;
   logic [4:0] rc [16] = '{3, 3, 0, 1, 1, 1, 4, 4, 6, 6, 8, 9, 10, 9, 11, 11};
   logic [7:0] rs [16] = '{8'h00, 8'h20, 8'hff, 8'hc0, 8'he0, 8'h80, 8'h20,
      8'h00, 8'h10, 8'hef, 8'h08, 8'h04, 8'h02, 8'hfb, 8'h01, 8'hfe};
   logic rx [16] = '{1, 0, 0, 1, 0, 0, 1, 0, 1, 0, 1, 1, 1, 0, 1, 0};
   logic [15:0] sp [8] = '{16'h0000, 16'h0100, 16'h0200, 16'h0300,
      16'h0400, 16'h0000, 16'h09c4, 16'h0700};
   logic [3:0] ls [5] = '{6, 7, 1, 2, 8};
   logic [4:0] ld [5] = '{5'h1f, 5'h00, 5'h01, 5'h1d, 5'h00};
   logic lx [5] = '{0, 1, 1, 0, 1};
   drs_top i_drs_top (.*);
   drs_far_end i_drs_far_end (.*);
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic summarize();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Far end plus design registers give up to three edges; four leaves margin
   task automatic settle();
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 90000) begin
         err_count++;
         summarize();
      end
   end
   initial begin
      {process_macro, comm_location_2, local_control, pump_fan_control,
         process_ref_followed, run_cmd, drive_ready, run_enable, running,
         fault_active, alarm_active, reverse_rotation, supv1_over,
         supv1_under, supv2_over, supv2_under, frequency_reached,
         analog_in_2, ai_set, ai1_min_pct, ai2_min_pct, ref2_low_limit,
         analog_1_time_constant, analog_2_time_constant, ref1_source,
         ref2_source, location_select, const_speed_select, ref1_low_limit,
         panel_ref, comm_set, relay_source, din_set} = '0;
      {ai1_max_pct, ai2_max_pct, ref2_high_limit} = {3{8'h64}};
      {ref1_high_limit, max_frequency} = {16'h0100, 16'h09c4};
      {const_speed_1, const_speed_2, const_speed_3, const_speed_4} =
         {16'h0100, 16'h0200, 16'h0300, 16'h0400};
      {const_speed_5, const_speed_6, const_speed_7} =
         {16'h8005, 16'h0fff, 16'h0700};
      reset = 1'b1;
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk_sys);
         relay_source <= rc[i];
         {drive_ready, run_enable, fault_active, reverse_rotation,
            supv1_under, supv2_over, supv2_under, frequency_reached} <= rs[i];
         settle();
         `CHK("relay_out_1", rx[i], relay_out_1)
      end
      @(posedge clk_sys);
      relay_source <= RLY_CONST;
      for (int s = 6; s <= 10; s++) begin
         sh = (s == 7 || s == 10) ? 2 : (s == 8) ? 3 : 0;
         for (int v = 0; v < ((s > 8) ? 8 : 4); v++) begin
            @(posedge clk_sys);
            const_speed_select <= 4'(s);
            din_set <= 5'(v << sh);
            settle();
            `CHK("const_speed_index", 3'(v), const_speed_index)
            `CHK("const_speed_ref", sp[v], const_speed_ref)
            `CHK("relay_out_1", v != 0, relay_out_1)
         end
      end
      `CHK("fallback_speed", 16'h0700, fallback_speed)
      for (int k = 0; k <= 5; k++) begin
         @(posedge clk_sys);
         const_speed_select <= 4'(k);
         din_set <= (k == 0) ? 5'h1f : 5'(1 << (k - 1));
         settle();
         `CHK("single_index", 3'(k != 0), const_speed_index)
         @(posedge clk_sys);
         din_set <= ~din_set;
         settle();
         `CHK("single_index", 3'h0, const_speed_index)
      end
      for (int j = 0; j < 3; j++) begin
         @(posedge clk_sys);
         const_speed_select <= CS_TRI123;
         din_set <= 5'h07;
         {process_ref_followed, pump_fan_control, local_control} <= 3'(1 << j);
         settle();
         `CHK("refused_index", 3'h0, const_speed_index)
      end
      @(posedge clk_sys);
      {process_ref_followed, pump_fan_control, local_control} <= 3'h0;
      relay_source <= RLY_EXT;
      settle();
      `CHK("relay_ext", 1'b1, relay_out_1)
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_sys);
         relay_source <= RLY_LOC2;
         comm_location_2 <= 1'b1;
         location_select <= ls[i];
         din_set <= ld[i];
         settle();
         `CHK("external_location_2", lx[i], external_location_2)
         `CHK("relay_loc2", lx[i], relay_out_1)
      end
      @(posedge clk_sys);
      {ref1_source, ref2_source} <= {SRC_COMM, SRC_COMM};
      comm_set <= 16'h0123;
      process_macro <= 1'b1;
      settle();
      `CHK("ext_ref1", 16'h0123, ext_ref1)
      `CHK("ext_ref2", 16'h0123, ext_ref2)
      `CHK("ref2_is_process", 1'b1, ref2_is_process)
      @(posedge clk_sys);
      ref1_source <= SRC_UPDN_KEEP;
      run_cmd <= 1'b1;
      din_set <= 5'h04;
      repeat (8100) @(posedge clk_sys);
      din_set <= 5'h00;
      run_cmd <= 1'b0;
      repeat (50) @(posedge clk_sys);
      run_cmd <= 1'b1;
      settle();
      `CHK("ref_kept", 1'b1, ext_ref1 >= 16'h3 && ext_ref1 <= 16'h5)
      @(posedge clk_sys);
      ref1_source <= SRC_UPDN_RST;
      run_cmd <= 1'b0;
      settle();
      @(posedge clk_sys);
      run_cmd <= 1'b1;
      settle();
      `CHK("ref_cleared", 16'h0000, ext_ref1)
      @(posedge clk_sys);
      ref1_source <= SRC_UPDN_45;
      din_set <= 5'h08;
      repeat (4100) @(posedge clk_sys);
      din_set <= 5'h00;
      settle();
      `CHK("ref_up45", 1'b1, ext_ref1 >= 16'h1 && ext_ref1 <= 16'h3)
      @(posedge clk_sys);
      {ref1_source, ref2_source} <= {SRC_COMM_SUM, SRC_COMM_MUL};
      ai_set <= AI_FULL;
      // Lands between the second and third floor steps: 1/16 of full scale
      repeat (60000) @(posedge clk_sys);
      #1;
      `CHK("ext_ref1_sum", 16'h0132, ext_ref1)
      `CHK("ext_ref2_mul", 16'h0012, ext_ref2)
      summarize();
   end
endmodule
